//--- logic/flash_guard_defs.vh
// offsets, field positions, reset values, clock period and operation times of the flash write/erase guard
`ifndef FLASH_GUARD_DEFS_VH
`define FLASH_GUARD_DEFS_VH

// ============================================================
// register offsets
`define OFS_PROGRAM_STORE_CONTROL   8'h8F
`define OFS_FLASH_LOCK_KEY          8'hB7
`define OFS_SUPPLY_MONITOR_CONTROL  8'hC0
`define OFS_RESET_SOURCE            8'hC1
`define OFS_IRQ_STATUS              8'hC2
`define OFS_IRQ_MASK                8'hC3
`define OFS_GUARD_STATUS            8'hC4

// ============================================================
// field positions
`define BIT_STORE_WRITE_ENABLE      0
`define BIT_PAGE_ERASE_ENABLE       1
`define BIT_SUPPLY_MONITOR_ENABLE   0
`define BIT_SUPPLY_MONITOR_LEVEL    1
`define BIT_SUPPLY_RESET_SELECT     1
`define EVT_OP_DONE                 0
`define EVT_LOCKOUT                 1
`define EVT_FLASH_ERROR             2
`define EVT_RANGE_REJECT            3

// ============================================================
// reset values and codes
`define RST_PROGRAM_STORE_CONTROL   8'h00
`define RST_SUPPLY_MONITOR_CONTROL  8'h00
`define RST_RESET_SOURCE            8'h00
`define RST_IRQ_MASK                4'h0
`define FIRST_KEY_CODE              8'hA5
`define SECOND_KEY_CODE             8'hF1
`define ERASED_BYTE                 8'hFF
`define SHORT_ADDRESS_LIMIT         16'h00FF

// ============================================================
// timing
`define CLK_PERIOD_NS               25
`define FLASH_WRITE_TIME_NS         20000
`define FLASH_ERASE_TIME_US         20000

`endif

//--- logic/flash_op_timer.v
// countdown timer that paces one flash write or erase
`timescale 1ns/1ps

module flash_op_timer
#(
  parameter WIDTH = 20
)
(
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // control
  input  wire             start,
  input  wire [WIDTH-1:0] cycles,
  // status
  output reg              busy,
  output reg              done
);

  reg [WIDTH-1:0] remaining;

  // load on start, count down, pulse done on the last cycle
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remaining <= {WIDTH{1'b0}};
      busy      <= 1'b0;
      done      <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        remaining <= cycles;
        busy      <= 1'b1;
      end
      else if (busy)
      begin
        if (remaining <= {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // flash_op_timer

//--- logic/flash_write_erase_guard.v
// flash write/erase guard: key lock, program/erase sequencing, stall and error reset
//
// Function
// RULE1 - programming only clears bits; erase sets every byte of the page to 0xFF
// RULE2 - hardware times each write and erase until completion, no polling needed
// RULE3 - cpu execution is stalled while a write or erase runs
// RULE4 - flash attempt with supply monitor disabled aborts and pulses flash-error reset
// RULE5 - software enables monitor at high level before selecting it as reset source
// RULE6 - short-address data moves cannot write or erase flash above 0x00FF
// RULE7 - key 0xA5 then 0xF1 must be written before each flash operation
// RULE8 - any number of cycles may separate the two key writes
// RULE9 - wrong key or reversed order locks flash out until system reset
// RULE10 - flash attempt before a correct key pair locks flash out until reset
// RULE11 - lock returns to locked after every completed write or erase
// RULE12 - erase and write enables both set: data move erases whole page, data ignored
// RULE13 - write enable set sends data moves to flash as a byte program, else disabled
// RULE14 - software should erase a location before programming it
// RULE15 - write enable clear: data moves reach data memory, flash and lock untouched
`timescale 1ns/1ps
`include "flash_guard_defs.vh"

module flash_write_erase_guard
#(
  parameter ADDR_WIDTH   = 12,
  parameter PAGE_WIDTH   = 9,
  parameter TIMER_WIDTH  = 20,
  parameter ERASE_CYCLES = (`FLASH_ERASE_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
)
(
  // clock and reset
  input  wire                  clk,
  input  wire                  reset_n,
  // register port
  input  wire [7:0]            reg_addr,
  input  wire [7:0]            reg_wdata,
  input  wire                  reg_wr,
  input  wire                  reg_rd,
  output reg  [7:0]            reg_rdata,
  // external data move writes from the core
  input  wire                  xdata_wr,
  input  wire [15:0]           xdata_addr,
  input  wire [7:0]            xdata_wdata,
  input  wire                  xdata_short,
  // ordinary data memory
  output reg                   ram_wr,
  output reg  [15:0]           ram_addr,
  output reg  [7:0]            ram_wdata,
  // flash read port
  input  wire [ADDR_WIDTH-1:0] flash_rd_addr,
  output reg  [7:0]            flash_rd_data,
  // core control
  output reg                   cpu_stall,
  output reg                   flash_error_reset,
  output reg                   irq
);

  // ============================================================
  // constants
  localparam [TIMER_WIDTH-1:0] WRITE_CYCLES =
    (`FLASH_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam [TIMER_WIDTH-1:0] ERASE_COUNT  = ERASE_CYCLES;
  localparam DEPTH = 1 << ADDR_WIDTH;

  // lock states
  localparam [1:0] LK_LOCKED   = 2'h0;
  localparam [1:0] LK_KEY1     = 2'h1;
  localparam [1:0] LK_ARMED    = 2'h2;
  localparam [1:0] LK_DISABLED = 2'h3;

  // operation states
  localparam [1:0] OP_IDLE  = 2'h0;
  localparam [1:0] OP_PROG  = 2'h1;
  localparam [1:0] OP_ERASE = 2'h2;

  // ============================================================
  // reset release
  reg rst_meta;
  reg rst_n;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ============================================================
  // state
  reg  [7:0]            program_store_control;
  reg  [7:0]            supply_monitor_control;
  reg  [7:0]            reset_source_register;
  reg  [3:0]            irq_status;
  reg  [3:0]            irq_mask;
  reg  [1:0]            lock_state;
  reg  [1:0]            op_state;
  reg  [ADDR_WIDTH-1:0] op_addr;
  reg  [PAGE_WIDTH:0]   erase_index;
  reg  [7:0]            flash_mem [0:DEPTH-1];
  reg                   timer_start;
  reg  [TIMER_WIDTH-1:0] timer_cycles;
  wire                  timer_busy;
  wire                  timer_done;
  reg  [3:0]            event_set;

  // register address match, used by several decoders
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  // ============================================================
  // decoding of a data move write
  wire store_write_enable = program_store_control[`BIT_STORE_WRITE_ENABLE];
  wire page_erase_enable  = program_store_control[`BIT_PAGE_ERASE_ENABLE];
  wire monitor_on         = supply_monitor_control[`BIT_SUPPLY_MONITOR_ENABLE];
  wire flash_attempt      = xdata_wr && store_write_enable && (op_state == OP_IDLE); // RULE13
  wire out_of_short_range = xdata_short && (xdata_addr > `SHORT_ADDRESS_LIMIT);
  wire key_write          = reg_wr && hit(reg_addr, `OFS_FLASH_LOCK_KEY);
  wire op_go              = flash_attempt && monitor_on && !out_of_short_range
                            && (lock_state == LK_ARMED);
  wire [ADDR_WIDTH-1:0] target = xdata_addr[ADDR_WIDTH-1:0];

  // ============================================================
  // lock and key sequencer
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lock_state <= LK_LOCKED;
    else if (lock_state == LK_DISABLED)
      lock_state <= LK_DISABLED;                       // RULE9
    else if (flash_attempt && monitor_on && !out_of_short_range
             && lock_state != LK_ARMED)
      lock_state <= LK_DISABLED;                       // RULE10
    else if (timer_done)
      lock_state <= LK_LOCKED;                         // RULE11
    else if (key_write)
    begin
      case (lock_state)
        LK_LOCKED:
          lock_state <= (reg_wdata == `FIRST_KEY_CODE) ? LK_KEY1 : LK_DISABLED;   // RULE7
        LK_KEY1:
          lock_state <= (reg_wdata == `SECOND_KEY_CODE) ? LK_ARMED : LK_DISABLED; // RULE8
        default:
          lock_state <= LK_DISABLED;                   // RULE9
      endcase
    end
  end

  // ============================================================
  // operation sequencer: start, erase walk, completion
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      op_state     <= OP_IDLE;
      op_addr      <= {ADDR_WIDTH{1'b0}};
      erase_index  <= {(PAGE_WIDTH+1){1'b0}};
      timer_start  <= 1'b0;
      timer_cycles <= {TIMER_WIDTH{1'b0}};
      cpu_stall    <= 1'b0;
    end
    else
    begin
      timer_start <= 1'b0;
      case (op_state)
        OP_IDLE:
        begin
          if (op_go)
          begin
            timer_start <= 1'b1;                       // RULE2
            cpu_stall   <= 1'b1;                       // RULE3
            erase_index <= {(PAGE_WIDTH+1){1'b0}};
            if (page_erase_enable)
            begin
              op_state     <= OP_ERASE;                // RULE12
              op_addr      <= {target[ADDR_WIDTH-1:PAGE_WIDTH], {PAGE_WIDTH{1'b0}}};
              timer_cycles <= ERASE_COUNT;
            end
            else
            begin
              op_state     <= OP_PROG;
              op_addr      <= target;
              timer_cycles <= WRITE_CYCLES;
            end
          end
        end
        OP_PROG, OP_ERASE:
        begin
          if (op_state == OP_ERASE && !erase_index[PAGE_WIDTH])
            erase_index <= erase_index + {{PAGE_WIDTH{1'b0}}, 1'b1};
          if (timer_done)
          begin
            op_state  <= OP_IDLE;
            cpu_stall <= 1'b0;                         // RULE3
          end
        end
        default:
          op_state <= OP_IDLE;
      endcase
    end
  end

  // ============================================================
  // flash array: program clears bits, erase walks the page to all ones
  always @(posedge clk)
  begin
    if (op_state == OP_IDLE && op_go && !page_erase_enable)
      flash_mem[target] <= flash_mem[target] & xdata_wdata;  // RULE1
    else if (op_state == OP_ERASE && !erase_index[PAGE_WIDTH])
      flash_mem[{op_addr[ADDR_WIDTH-1:PAGE_WIDTH], erase_index[PAGE_WIDTH-1:0]}]
        <= `ERASED_BYTE;                                      // RULE1
    flash_rd_data <= flash_mem[flash_rd_addr];
  end

  flash_op_timer #(.WIDTH(TIMER_WIDTH)) u_timer
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (timer_start),
    .cycles (timer_cycles),
    .busy   (timer_busy),
    .done   (timer_done)
  );

  // ============================================================
  // data memory pass-through and flash error reset
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ram_wr            <= 1'b0;
      ram_addr          <= 16'h0000;
      ram_wdata         <= 8'h00;
      flash_error_reset <= 1'b0;
    end
    else
    begin
      ram_wr            <= xdata_wr && !store_write_enable;  // RULE15
      ram_addr          <= xdata_addr;
      ram_wdata         <= xdata_wdata;
      flash_error_reset <= flash_attempt && !monitor_on;     // RULE4
    end
  end

  // ============================================================
  // events for the interrupt status
  always @*
  begin
    event_set = 4'h0;
    event_set[`EVT_OP_DONE]     = timer_done;
    event_set[`EVT_LOCKOUT]     = (lock_state != LK_DISABLED) &&
                                  ((key_write && ((lock_state == LK_LOCKED &&
                                    reg_wdata != `FIRST_KEY_CODE) ||
                                   (lock_state == LK_KEY1 &&
                                    reg_wdata != `SECOND_KEY_CODE) ||
                                    lock_state == LK_ARMED)) ||
                                   (flash_attempt && monitor_on && !out_of_short_range &&
                                    lock_state != LK_ARMED));
    event_set[`EVT_FLASH_ERROR] = flash_attempt && !monitor_on;
    event_set[`EVT_RANGE_REJECT] = flash_attempt && monitor_on && out_of_short_range; // RULE6
  end

  // ============================================================
  // software registers; hardware set wins over write-one-to-clear
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      program_store_control  <= `RST_PROGRAM_STORE_CONTROL;
      supply_monitor_control <= `RST_SUPPLY_MONITOR_CONTROL;
      reset_source_register  <= `RST_RESET_SOURCE;
      irq_mask               <= `RST_IRQ_MASK;
      irq_status             <= 4'h0;
      irq                    <= 1'b0;
    end
    else
    begin
      if (reg_wr && hit(reg_addr, `OFS_PROGRAM_STORE_CONTROL))
        program_store_control <= {6'h00, reg_wdata[1:0]};
      else if (reg_wr && hit(reg_addr, `OFS_SUPPLY_MONITOR_CONTROL))
        supply_monitor_control <= {6'h00, reg_wdata[1:0]};
      else if (reg_wr && hit(reg_addr, `OFS_RESET_SOURCE))
        reset_source_register <= {6'h00, reg_wdata[`BIT_SUPPLY_RESET_SELECT], 1'b0};
      else if (reg_wr && hit(reg_addr, `OFS_IRQ_MASK))
        irq_mask <= reg_wdata[3:0];
      if (reg_wr && hit(reg_addr, `OFS_IRQ_STATUS))
        irq_status <= (irq_status & ~reg_wdata[3:0]) | event_set;
      else
        irq_status <= irq_status | event_set;
      irq <= |((irq_status | event_set) & irq_mask &
               ~((reg_wr && hit(reg_addr, `OFS_IRQ_STATUS)) ? (reg_wdata[3:0] & ~event_set)
                                                             : 4'h0));
    end
  end

  // ============================================================
  // read data, valid only in the cycle after the strobe
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else if (hit(reg_addr, `OFS_PROGRAM_STORE_CONTROL))
      reg_rdata <= program_store_control;
    else if (hit(reg_addr, `OFS_SUPPLY_MONITOR_CONTROL))
      reg_rdata <= supply_monitor_control;
    else if (hit(reg_addr, `OFS_RESET_SOURCE))
      reg_rdata <= reset_source_register;
    else if (hit(reg_addr, `OFS_IRQ_STATUS))
      reg_rdata <= {4'h0, irq_status};
    else if (hit(reg_addr, `OFS_IRQ_MASK))
      reg_rdata <= {4'h0, irq_mask};
    else if (hit(reg_addr, `OFS_GUARD_STATUS))
      reg_rdata <= {3'h0, timer_busy, op_state, lock_state};
    else
      reg_rdata <= 8'h00;                              // key register and unmapped read zero
  end

endmodule // flash_write_erase_guard

//--- tb/flash_write_erase_guard_assertions.sv
// port checker for the flash write/erase guard
`timescale 1ns/1ps
`include "flash_guard_defs.vh"

module flash_write_erase_guard_checker
#(
  parameter int ERASE_CYCLES = 600
)
(
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // register and data-move inputs
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        xdata_wr,
  input wire logic [15:0] xdata_addr,
  input wire logic [7:0]  xdata_wdata,
  input wire logic        xdata_short,
  // outputs under watch
  input wire logic        ram_wr,
  input wire logic [15:0] ram_addr,
  input wire logic [7:0]  ram_wdata,
  input wire logic        cpu_stall,
  input wire logic        flash_error_reset
);
  localparam int WR = `FLASH_WRITE_TIME_NS / `CLK_PERIOD_NS;
  localparam int MIN_RUN = (ERASE_CYCLES < WR ? ERASE_CYCLES : WR) - 2;
  localparam int MAX_RUN = (ERASE_CYCLES > WR ? ERASE_CYCLES : WR) + 4;
  logic swe;
  logic mon;
  int   run;

  // ==========================================================
  // shadow enables and stall length
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      swe <= 1'b0;
      mon <= 1'b0;
      run <= 0;
    end
    else
    begin
      if (reg_wr && reg_addr == `OFS_PROGRAM_STORE_CONTROL)
        swe <= reg_wdata[`BIT_STORE_WRITE_ENABLE];
      if (reg_wr && reg_addr == `OFS_SUPPLY_MONITOR_CONTROL)
        mon <= reg_wdata[`BIT_SUPPLY_MONITOR_ENABLE];
      run <= cpu_stall ? run + 1 : 0;
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // properties
  a_ram_pass: assert property (
    xdata_wr && !swe |=> ram_wr && ram_addr == $past(xdata_addr) && ram_wdata == $past(xdata_wdata))
    else $error("data move missed data memory");
  a_flash_no_ram: assert property (
    xdata_wr && swe |=> !ram_wr) else $error("flash move reached data memory");
  a_error_reset: assert property (
    xdata_wr && swe && !mon && !cpu_stall |=> flash_error_reset && !cpu_stall)
    else $error("no error reset with monitor off");
  a_error_pulse: assert property (
    flash_error_reset |=> !flash_error_reset) else $error("error reset too long");
  a_short_reject: assert property (
    xdata_wr && swe && mon && xdata_short && xdata_addr > `SHORT_ADDRESS_LIMIT && !cpu_stall
    |=> !cpu_stall && !flash_error_reset) else $error("short move reached flash");
  a_stall_long: assert property (
    $fell(cpu_stall) |-> run >= MIN_RUN) else $error("stall ended early");
  a_stall_bound: assert property (
    cpu_stall |-> run <= MAX_RUN) else $error("operation never ends");
  a_stall_cause: assert property (
    $rose(cpu_stall) |-> $past(xdata_wr && swe && mon)) else $error("stall without flash move");
endmodule // flash_write_erase_guard_checker

bind flash_write_erase_guard flash_write_erase_guard_checker #(.ERASE_CYCLES(ERASE_CYCLES)) u_chk
  (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .xdata_wr, .xdata_addr, .xdata_wdata,
   .xdata_short, .ram_wr, .ram_addr, .ram_wdata, .cpu_stall, .flash_error_reset);

//--- tb/core_move_model.sv
// processor core model issuing data-move writes
`timescale 1ns/1ps

module core_move_model
(
  // clock and stall
  input  wire logic        clk,
  input  wire logic        cpu_stall,
  // data-move write
  output logic             xdata_wr,
  output logic [15:0]      xdata_addr,
  output logic [7:0]       xdata_wdata,
  output logic             xdata_short
);
  initial {xdata_wr, xdata_addr, xdata_wdata, xdata_short} = 26'h0;

  // one strobe; released lines show the inverse so nothing stale looks valid
  task automatic move(input logic [15:0] a, input logic [7:0] d, input logic s,
                      output logic late);
    int n;
    n = 0;
    @(posedge clk);
    while (cpu_stall === 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    late = (n == 2000);
    xdata_wr <= 1'b1;
    xdata_addr <= a;
    xdata_wdata <= d;
    xdata_short <= s;
    @(posedge clk);
    xdata_wr <= 1'b0;
    xdata_addr <= ~a;
    xdata_wdata <= ~d;
    xdata_short <= ~s;
  endtask
endmodule // core_move_model

//--- tb/flash_write_erase_guard_test.sv
// self-checking bench for the flash write/erase guard
`timescale 1ns/1ps
`include "flash_guard_defs.vh"

module flash_write_erase_guard_test;
  localparam int ERASE = 600;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [11:0] flash_rd_addr = 12'h000;
  logic        fl_rq = 1'b0;
  logic [1:0]  pend = 2'h0;
  logic [31:0] seed = 32'd16029;
  logic [7:0]  expq[$];
  logic [7:0]  r1;
  logic [15:0] a16;
  logic        late;
  logic        ran;
  int          err_count = 0;
  int          check_count = 0;
  int          n;
  wire [7:0]   reg_rdata, flash_rd_data, ram_wdata, xdata_wdata;
  wire [15:0]  xdata_addr, ram_addr;
  wire         xdata_wr, xdata_short, ram_wr, cpu_stall, flash_error_reset, irq;
  logic [7:0]  rst_tab[8] = '{`OFS_PROGRAM_STORE_CONTROL, `OFS_SUPPLY_MONITOR_CONTROL,
    `OFS_RESET_SOURCE, `OFS_IRQ_STATUS, `OFS_IRQ_MASK, `OFS_FLASH_LOCK_KEY, 8'h10,
    `OFS_GUARD_STATUS};
  logic [7:0]  bad[2] = '{`SECOND_KEY_CODE, 8'h5A};

  always #12.5 clk = ~clk;

  flash_write_erase_guard #(.ERASE_CYCLES(ERASE)) dut (.clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .xdata_wr, .xdata_addr, .xdata_wdata, .xdata_short, .ram_wr,
    .ram_addr, .ram_wdata, .flash_rd_addr, .flash_rd_data, .cpu_stall, .flash_error_reset, .irq);
  core_move_model core (.clk, .cpu_stall, .xdata_wr, .xdata_addr, .xdata_wdata, .xdata_short);

  // ==========================================================
  // helpers
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    expq.push_back(want);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic fr(input logic [11:0] a, input logic [7:0] want);
    @(posedge clk);
    flash_rd_addr <= a;
    fl_rq <= 1'b1;
    expq.push_back(want);
    @(posedge clk);
    fl_rq <= 1'b0;
  endtask

  task automatic keys(input int gap);
    wr(`OFS_FLASH_LOCK_KEY, `FIRST_KEY_CODE);
    repeat (gap) @(posedge clk);
    wr(`OFS_FLASH_LOCK_KEY, `SECOND_KEY_CODE);
  endtask

  // move, note whether an operation started, then wait it out
  task automatic mv(input logic [15:0] a, input logic [7:0] d, input logic s);
    core.move(a, d, s, late);
    #1;
    ran = cpu_stall;
    n = 0;
    while (cpu_stall === 1'b1 && n < 2000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (late || n == 2000)
    begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // watcher: compare each read result against the oldest note
  always @(posedge clk)
  begin
    if (pend != 2'h0 && expq.size() > 0)
      check(pend[0] ? reg_rdata : flash_rd_data, expq.pop_front());
    pend <= {fl_rq, reg_rd};
  end

  // ==========================================================
  // main sequence
  initial
  begin
    do_reset();
    foreach (rst_tab[i]) rd(rst_tab[i], 8'h00);
    wr(`OFS_SUPPLY_MONITOR_CONTROL, 8'h03);
    wr(`OFS_RESET_SOURCE, 8'h02);
    rd(`OFS_RESET_SOURCE, 8'h02);
    repeat (3)
    begin
      a16 = {rnd(), rnd()};
      r1 = rnd();
      mv(a16, r1, 1'b0);
      check({7'h00, ram_wr}, 8'h01);
      check(ram_wdata, r1);
      check(ram_addr[15:8], a16[15:8]);
      check(ram_addr[7:0], a16[7:0]);
    end
    rd(`OFS_IRQ_STATUS, 8'h00);
    $display("test data memory done");
    wr(`OFS_IRQ_MASK, 8'h0F);
    keys(5);
    rd(`OFS_GUARD_STATUS, 8'h02);
    wr(`OFS_PROGRAM_STORE_CONTROL, 8'h03);
    mv(16'h0010, rnd(), 1'b0);
    check({7'h00, ran}, 8'h01);
    fr(12'h000, `ERASED_BYTE);
    fr(12'h1FF, `ERASED_BYTE);
    rd(`OFS_IRQ_STATUS, 8'h01);
    check({7'h00, irq}, 8'h01);
    wr(`OFS_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h00);
    wr(`OFS_IRQ_STATUS, 8'h01);
    wr(`OFS_IRQ_MASK, 8'h0F);
    $display("test erase done");
    keys(0);
    wr(`OFS_PROGRAM_STORE_CONTROL, 8'h01);
    mv(16'h0120, 8'h00, 1'b1);
    check({7'h00, ran}, 8'h00);
    check({7'h00, flash_error_reset}, 8'h00);
    rd(`OFS_IRQ_STATUS, 8'h08);
    wr(`OFS_IRQ_STATUS, 8'h08);
    r1 = rnd();
    mv(16'h0120, r1, 1'b0);
    fr(12'h120, r1);
    keys(2);
    mv(16'h0120, ~r1 | 8'h5A, 1'b0);
    fr(12'h120, r1 & (~r1 | 8'h5A));
    rd(`OFS_IRQ_STATUS, 8'h01);
    wr(`OFS_IRQ_STATUS, 8'h01);
    $display("test program done");
    wr(`OFS_SUPPLY_MONITOR_CONTROL, 8'h00);
    mv(16'h0130, 8'h00, 1'b0);
    check({7'h00, flash_error_reset}, 8'h01);
    check({7'h00, ram_wr}, 8'h00);
    rd(`OFS_IRQ_STATUS, 8'h04);
    fr(12'h130, `ERASED_BYTE);
    wr(`OFS_IRQ_STATUS, 8'h04);
    wr(`OFS_SUPPLY_MONITOR_CONTROL, 8'h03);
    mv(16'h0140, 8'h00, 1'b0);
    check({7'h00, ran}, 8'h00);
    rd(`OFS_IRQ_STATUS, 8'h02);
    rd(`OFS_GUARD_STATUS, 8'h03);
    keys(0);
    mv(16'h0140, 8'h00, 1'b0);
    check({7'h00, ran}, 8'h00);
    fr(12'h140, `ERASED_BYTE);
    $display("test lockout done");
    foreach (bad[i])
    begin
      do_reset();
      wr(`OFS_SUPPLY_MONITOR_CONTROL, 8'h03);
      wr(`OFS_PROGRAM_STORE_CONTROL, 8'h01);
      wr(`OFS_FLASH_LOCK_KEY, bad[i]);
      keys(0);
      mv(16'h0150, 8'h00, 1'b0);
      check({7'h00, ran}, 8'h00);
      fr(12'h150, `ERASED_BYTE);
    end
    $display("test bad keys done");
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule // flash_write_erase_guard_test
